// File: rtl/acc_top.sv
// Digital control around the on-chip voltage comparator: input selection,
// result synchronisation, event detection, interrupt and capture routing,
// and pin input buffer disables.
// Assumes analog levels arrive as unsigned codes from outside the clock domain,
// and converter mux settings come from logic on the same clock.
//
// Strobed register access was left to the implementer.

module acc_top (
	input  wire logic                                                 CLK_I,
	input  wire logic                                                 RST_I,
	input  wire logic                                                 CE_I,
	input  wire logic [7:0]                                           REG_ADDR_I,
	input  wire logic [7:0]                                           REG_WDATA_I,
	input  wire logic                                                 REG_WE_I,
	input  wire logic                                                 REG_RE_I,
	output logic      [7:0]                                           REG_RDATA_O,
	input  wire logic [acc_pkg::LEVEL_W-1:0]                          POS_PIN_LEVEL_I,
	input  wire logic [acc_pkg::LEVEL_W-1:0]                          NEG_PIN_LEVEL_I,
	input  wire logic [acc_pkg::LEVEL_W-1:0]                          BANDGAP_LEVEL_I,
	input  wire logic [acc_pkg::CHAN_N-1:0][acc_pkg::LEVEL_W-1:0]     CHANNEL_LEVEL_I,
	input  wire logic                                                 NEG_MUX_ENABLE_I,
	input  wire logic                                                 CONVERTER_ENABLE_I,
	input  wire logic [acc_pkg::CHSEL_W-1:0]                          CHANNEL_SELECT_I,
	input  wire logic                                                 GLOBAL_IRQ_ENABLE_I,
	input  wire logic                                                 IRQ_VECTOR_TAKEN_I,
	output logic                                                      IRQ_O,
	output logic                                                      COMPARATOR_POWER_O,
	output logic                                                      CAPTURE_INPUT_O,
	output logic                                                      CAPTURE_ROUTE_O,
	input  wire logic                                                 POS_PIN_DIGITAL_I,
	input  wire logic                                                 NEG_PIN_DIGITAL_I,
	output logic                                                      POS_PIN_READ_O,
	output logic                                                      NEG_PIN_READ_O,
	output logic                                                      POS_BUFFER_EN_O,
	output logic                                                      NEG_BUFFER_EN_O
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic       power_off;
		logic       bandgap_sel;
		logic       event_flag;
		logic       irq_en;
		logic       capture_route;
		logic [1:0] irq_mode;
		logic       neg_buf_off;
		logic       pos_buf_off;
		logic       prev_result;
		logic [7:0] rdata;
		logic       capture;
		logic       pos_read;
		logic       neg_read;
	} acc_state_t;

	localparam acc_state_t ST_RESET = '{
		power_off:     acc_pkg::CTRL_STATUS_RESET[acc_pkg::POWER_OFF_BIT],
		bandgap_sel:   acc_pkg::CTRL_STATUS_RESET[acc_pkg::BANDGAP_BIT],
		event_flag:    acc_pkg::CTRL_STATUS_RESET[acc_pkg::EVENT_FLAG_BIT],
		irq_en:        acc_pkg::CTRL_STATUS_RESET[acc_pkg::IRQ_EN_BIT],
		capture_route: acc_pkg::CTRL_STATUS_RESET[acc_pkg::CAPTURE_BIT],
		irq_mode:      acc_pkg::CTRL_STATUS_RESET[acc_pkg::MODE_HI_BIT:acc_pkg::MODE_LO_BIT],
		neg_buf_off:   acc_pkg::INPUT_DIS_RESET[acc_pkg::NEG_BUF_OFF_BIT],
		pos_buf_off:   acc_pkg::INPUT_DIS_RESET[acc_pkg::POS_BUF_OFF_BIT],
		prev_result:   acc_pkg::SYNC_RESET,
		rdata:         8'h00,
		capture:       acc_pkg::SYNC_RESET,
		pos_read:      acc_pkg::SYNC_RESET,
		neg_read:      acc_pkg::SYNC_RESET
	};

	acc_state_t q;
	acc_state_t d;

	logic [acc_pkg::LEVEL_W-1:0] pos_level;
	logic [acc_pkg::LEVEL_W-1:0] neg_level;
	logic                        raw_result;
	logic [acc_pkg::SYNC_W-1:0]  sync_in;
	logic [acc_pkg::SYNC_W-1:0]  sync_out;
	logic                        cmp_sync;
	logic                        pos_sync;
	logic                        neg_sync;
	logic                        cmp_event;
	logic                        flag_clear;
	logic                        wr_ctrl;
	logic                        wr_dis;
	logic                        wr_clr;
	logic                        wr_en;
	logic [7:0]                  ctrl_view;
	logic [7:0]                  dis_view;

	// ------------------------------------------------------------------
	// Input selection and comparison
	// ------------------------------------------------------------------
	always_comb begin
		if (q.bandgap_sel) begin
			pos_level = BANDGAP_LEVEL_I;
		end else begin
			pos_level = POS_PIN_LEVEL_I;
		end
		if (NEG_MUX_ENABLE_I && !CONVERTER_ENABLE_I) begin
			neg_level = CHANNEL_LEVEL_I[CHANNEL_SELECT_I];
		end else begin
			neg_level = NEG_PIN_LEVEL_I;
		end
	end

	// Powered-down comparator gives a low result
	assign raw_result = !q.power_off && (pos_level > neg_level);

	// ------------------------------------------------------------------
	// Synchronisers
	// ------------------------------------------------------------------
	assign sync_in = {NEG_PIN_DIGITAL_I, POS_PIN_DIGITAL_I, raw_result};

	acc_sync #(
		.W (acc_pkg::SYNC_W)
	) u_sync (
		.clk_i   (CLK_I),
		.rst_i   (RST_I),
		.ce_i    (CE_I),
		.async_i (sync_in),
		.sync_o  (sync_out)
	);

	assign cmp_sync = sync_out[0];
	assign pos_sync = sync_out[1];
	assign neg_sync = sync_out[2];

	// ------------------------------------------------------------------
	// Register views and write decode
	// ------------------------------------------------------------------
	always_comb begin
		ctrl_view                            = 8'h00;
		ctrl_view[acc_pkg::POWER_OFF_BIT]    = q.power_off;
		ctrl_view[acc_pkg::BANDGAP_BIT]      = q.bandgap_sel;
		ctrl_view[acc_pkg::RESULT_BIT]       = cmp_sync;
		ctrl_view[acc_pkg::EVENT_FLAG_BIT]   = q.event_flag;
		ctrl_view[acc_pkg::IRQ_EN_BIT]       = q.irq_en;
		ctrl_view[acc_pkg::CAPTURE_BIT]      = q.capture_route;
		ctrl_view[acc_pkg::MODE_HI_BIT]      = q.irq_mode[1];
		ctrl_view[acc_pkg::MODE_LO_BIT]      = q.irq_mode[0];
		dis_view                             = 8'h00;
		dis_view[acc_pkg::NEG_BUF_OFF_BIT]   = q.neg_buf_off;
		dis_view[acc_pkg::POS_BUF_OFF_BIT]   = q.pos_buf_off;
	end

	assign wr_ctrl = REG_WE_I && (REG_ADDR_I == acc_pkg::ADDR_CTRL_STATUS);
	assign wr_dis  = REG_WE_I && (REG_ADDR_I == acc_pkg::ADDR_INPUT_DIS);
	assign wr_clr  = REG_WE_I && (REG_ADDR_I == acc_pkg::ADDR_IRQ_CLEAR);
	assign wr_en   = REG_WE_I && (REG_ADDR_I == acc_pkg::ADDR_IRQ_ENABLE);

	// ------------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------------
	always_comb begin
		d = q;
		// Edge detection against the previous synchronised result
		case (q.irq_mode)
			acc_pkg::MODE_TOGGLE: begin
				cmp_event = cmp_sync != q.prev_result;
			end
			acc_pkg::MODE_FALL: begin
				cmp_event = q.prev_result && !cmp_sync;
			end
			acc_pkg::MODE_RISE: begin
				cmp_event = !q.prev_result && cmp_sync;
			end
			default: begin
				cmp_event = 1'b0;
			end
		endcase
		d.prev_result = cmp_sync;

		// Flag: set wins over any clear in the same cycle
		flag_clear = IRQ_VECTOR_TAKEN_I
			|| (wr_ctrl && REG_WDATA_I[acc_pkg::EVENT_FLAG_BIT])
			|| (wr_clr && REG_WDATA_I[acc_pkg::IRQ_EVENT_BIT]);
		d.event_flag = cmp_event || (q.event_flag && !flag_clear);

		// Register writes; the result bit has no storage
		if (wr_ctrl) begin
			d.power_off     = REG_WDATA_I[acc_pkg::POWER_OFF_BIT];
			d.bandgap_sel   = REG_WDATA_I[acc_pkg::BANDGAP_BIT];
			d.irq_en        = REG_WDATA_I[acc_pkg::IRQ_EN_BIT];
			d.capture_route = REG_WDATA_I[acc_pkg::CAPTURE_BIT];
			d.irq_mode      = REG_WDATA_I[acc_pkg::MODE_HI_BIT:acc_pkg::MODE_LO_BIT];
		end else if (wr_dis) begin
			d.neg_buf_off   = REG_WDATA_I[acc_pkg::NEG_BUF_OFF_BIT];
			d.pos_buf_off   = REG_WDATA_I[acc_pkg::POS_BUF_OFF_BIT];
		end else if (wr_en) begin
			d.irq_en        = REG_WDATA_I[acc_pkg::IRQ_EVENT_BIT];
		end

		// Read data, valid in the cycle after the strobe only
		d.rdata = 8'h00;
		if (REG_RE_I) begin
			if (REG_ADDR_I == acc_pkg::ADDR_CTRL_STATUS) begin
				d.rdata = ctrl_view;
			end else if (REG_ADDR_I == acc_pkg::ADDR_INPUT_DIS) begin
				d.rdata = dis_view;
			end else if (REG_ADDR_I == acc_pkg::ADDR_IRQ_STATUS) begin
				d.rdata[acc_pkg::IRQ_EVENT_BIT] = q.event_flag;
			end else if (REG_ADDR_I == acc_pkg::ADDR_IRQ_ENABLE) begin
				d.rdata[acc_pkg::IRQ_EVENT_BIT] = q.irq_en;
			end else begin
				d.rdata = 8'h00;
			end
		end

		// Capture routing and pin read values
		d.capture  = q.capture_route && cmp_sync;
		d.pos_read = pos_sync && !q.pos_buf_off;
		d.neg_read = neg_sync && !q.neg_buf_off;
	end

	always_ff @(posedge CLK_I) begin
		if (RST_I) begin
			q <= ST_RESET;
		end else if (CE_I) begin
			q <= d;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	assign REG_RDATA_O        = q.rdata;
	assign IRQ_O              = q.event_flag && q.irq_en && GLOBAL_IRQ_ENABLE_I;
	assign COMPARATOR_POWER_O = !q.power_off;
	assign CAPTURE_INPUT_O    = q.capture;
	assign CAPTURE_ROUTE_O    = q.capture_route;
	assign POS_PIN_READ_O     = q.pos_read;
	assign NEG_PIN_READ_O     = q.neg_read;
	assign POS_BUFFER_EN_O    = !q.pos_buf_off;
	assign NEG_BUFFER_EN_O    = !q.neg_buf_off;

	// ------------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge CLK_I);
	endclocking

	default disable iff (RST_I);

	AST_RAW_COMPARE: assert property (
		raw_result == (!ctrl_view[acc_pkg::POWER_OFF_BIT]
			&& ((ctrl_view[acc_pkg::BANDGAP_BIT] ? BANDGAP_LEVEL_I : POS_PIN_LEVEL_I)
			> ((NEG_MUX_ENABLE_I && !CONVERTER_ENABLE_I)
			? CHANNEL_LEVEL_I[CHANNEL_SELECT_I] : NEG_PIN_LEVEL_I)))
	) else $error("raw result disagrees with selected levels");

	AST_SYNC_LATENCY: assert property (
		(CE_I ##1 CE_I) |=> (cmp_sync == $past(raw_result, 2))
	) else $error("synchronised result not two edges behind raw");

	AST_RESULT_READ: assert property (
		(CE_I && REG_RE_I && REG_ADDR_I == acc_pkg::ADDR_CTRL_STATUS)
		|=> (REG_RDATA_O[acc_pkg::RESULT_BIT] == $past(cmp_sync))
	) else $error("result bit read does not show synchronised result");

	AST_NEG_CHANNEL: assert property (
		(NEG_MUX_ENABLE_I && !CONVERTER_ENABLE_I)
		|-> (neg_level == CHANNEL_LEVEL_I[CHANNEL_SELECT_I])
	) else $error("negative input not the selected channel");

	AST_NEG_PIN: assert property (
		(!NEG_MUX_ENABLE_I || CONVERTER_ENABLE_I) |-> (neg_level == NEG_PIN_LEVEL_I)
	) else $error("negative input not the dedicated pin");

	AST_POS_SELECT: assert property (
		pos_level == (q.bandgap_sel ? BANDGAP_LEVEL_I : POS_PIN_LEVEL_I)
	) else $error("positive input selection wrong");

	AST_POWER_WRITE: assert property (
		(CE_I && wr_ctrl)
		|=> (COMPARATOR_POWER_O == !$past(REG_WDATA_I[acc_pkg::POWER_OFF_BIT]))
	) else $error("power state did not follow write");

	AST_FLAG_SET: assert property (
		(CE_I && cmp_event) |=> q.event_flag
	) else $error("event did not set flag");

	AST_RISE_EVENT: assert property (
		(q.irq_mode == acc_pkg::MODE_RISE) |-> (cmp_event == (cmp_sync && !q.prev_result))
	) else $error("rising mode event wrong");

	AST_RESERVED_MODE: assert property (
		(q.irq_mode == acc_pkg::MODE_RESERVED) |-> !cmp_event
	) else $error("reserved mode produced an event");

	AST_FLAG_VECTOR: assert property (
		(CE_I && IRQ_VECTOR_TAKEN_I && !cmp_event) |=> !q.event_flag
	) else $error("vector taken did not clear flag");

	AST_FLAG_WRITE_ZERO: assert property (
		(CE_I && q.event_flag && wr_ctrl && !REG_WDATA_I[acc_pkg::EVENT_FLAG_BIT]
			&& !IRQ_VECTOR_TAKEN_I) |=> q.event_flag
	) else $error("writing zero cleared the flag");

	AST_IRQ_LEVEL: assert property (
		IRQ_O == (ctrl_view[acc_pkg::EVENT_FLAG_BIT] && ctrl_view[acc_pkg::IRQ_EN_BIT]
			&& GLOBAL_IRQ_ENABLE_I)
	) else $error("interrupt request level wrong");

	AST_CAPTURE_ROUTE: assert property (
		(CE_I ##1 1'b1) |-> (CAPTURE_INPUT_O == $past(q.capture_route && cmp_sync))
	) else $error("capture input not routed result");

	AST_CAPTURE_OFF: assert property (
		(!q.capture_route && !$past(q.capture_route)) |-> !CAPTURE_INPUT_O
	) else $error("capture input active with routing off");

	AST_PIN_READ_ZERO: assert property (
		(q.pos_buf_off && $past(q.pos_buf_off)) |-> !POS_PIN_READ_O
	) else $error("disabled pin read not zero");

	AST_DIS_UPPER: assert property (
		(CE_I && REG_RE_I && REG_ADDR_I == acc_pkg::ADDR_INPUT_DIS)
		|=> (REG_RDATA_O[7:2] == 6'h00)
	) else $error("input disable upper bits not zero");

	COV_IRQ_RAISED: cover property (
		q.irq_en && GLOBAL_IRQ_ENABLE_I && !q.event_flag ##1 IRQ_O
	);

	COV_FALL_EVENT: cover property (
		(q.irq_mode == acc_pkg::MODE_FALL) && cmp_event
	);

	COV_CHANNEL_MUX: cover property (
		NEG_MUX_ENABLE_I && !CONVERTER_ENABLE_I && raw_result
	);

	COV_CAPTURE: cover property (
		$rose(CAPTURE_INPUT_O)
	);

endmodule

// File: rtl/acc_pkg.sv
// Constants shared by the comparator control block: register map, field layout,
// reset values, interrupt mode codes and analog level widths.
// Assumes an 8-bit register port and one system clock.
package acc_pkg;

	// ------------------------------------------------------------------
	// Analog level representation
	// ------------------------------------------------------------------
	localparam int unsigned LEVEL_W = 10;
	localparam int unsigned CHAN_N  = 8;
	localparam int unsigned CHSEL_W = 3;
	localparam int unsigned SYNC_W  = 3;

	// ------------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL_STATUS = 8'h50;
	localparam logic [7:0] ADDR_INPUT_DIS   = 8'h7F;
	localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h60;
	localparam logic [7:0] ADDR_IRQ_CLEAR   = 8'h61;
	localparam logic [7:0] ADDR_IRQ_ENABLE  = 8'h62;

	// ------------------------------------------------------------------
	// Control and status register fields
	// ------------------------------------------------------------------
	localparam int unsigned POWER_OFF_BIT   = 7;
	localparam int unsigned BANDGAP_BIT     = 6;
	localparam int unsigned RESULT_BIT      = 5;
	localparam int unsigned EVENT_FLAG_BIT  = 4;
	localparam int unsigned IRQ_EN_BIT      = 3;
	localparam int unsigned CAPTURE_BIT     = 2;
	localparam int unsigned MODE_HI_BIT     = 1;
	localparam int unsigned MODE_LO_BIT     = 0;

	// ------------------------------------------------------------------
	// Input disable and interrupt register fields
	// ------------------------------------------------------------------
	localparam int unsigned NEG_BUF_OFF_BIT = 1;
	localparam int unsigned POS_BUF_OFF_BIT = 0;
	localparam int unsigned IRQ_EVENT_BIT   = 0;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] CTRL_STATUS_RESET = 8'h00;
	localparam logic [7:0] INPUT_DIS_RESET   = 8'h00;
	localparam logic       SYNC_RESET        = 1'b0;

	// ------------------------------------------------------------------
	// Interrupt mode codes
	// ------------------------------------------------------------------
	localparam logic [1:0] MODE_TOGGLE   = 2'h0;
	localparam logic [1:0] MODE_RESERVED = 2'h1;
	localparam logic [1:0] MODE_FALL     = 2'h2;
	localparam logic [1:0] MODE_RISE     = 2'h3;

endpackage

// File: rtl/acc_sync.sv
// Two-stage synchroniser for signals arriving from outside the clock domain.
// Assumes the caller reads only the second stage output.
module acc_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         ce_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} acc_sync_state_t;

	acc_sync_state_t q;
	acc_sync_state_t d;

	always_comb begin
		d    = q;
		d.s1 = async_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= {(2 * W){acc_pkg::SYNC_RESET}};
		end else if (ce_i) begin
			q <= d;
		end
	end

	assign sync_o = q.s2;

endmodule

// File: sim/acc_far.sv
// Far-side model: analog levels at the comparator inputs, digital pin values,
// and a timer capture front end that counts rising edges of the routed result.
// Assumes the bench calls its tasks right after a rising clock edge.
module acc_far (
	input  wire logic                                             clk_i,
	input  wire logic                                             capture_i,
	output logic      [acc_pkg::LEVEL_W-1:0]                      pos_o,
	output logic      [acc_pkg::LEVEL_W-1:0]                      neg_o,
	output logic      [acc_pkg::LEVEL_W-1:0]                      bg_o,
	output logic      [acc_pkg::CHAN_N-1:0][acc_pkg::LEVEL_W-1:0] chan_o,
	output logic                                                  pos_dig_o,
	output logic                                                  neg_dig_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        cap_q = 1'b0;
	int unsigned cap_edges = 0;
	initial begin
		pos_o = '0;
		neg_o = '0;
		bg_o = '0;
		chan_o = '0;
		pos_dig_o = 1'b0;
		neg_dig_o = 1'b0;
	end
	// Timer front end: counts rising edges of its capture input
	always @(posedge clk_i) begin
		cap_q <= capture_i;
		if (capture_i && !cap_q) begin
			cap_edges <= cap_edges + 1;
		end
	end
	task automatic set_lv(input logic [acc_pkg::LEVEL_W-1:0] p, input logic [acc_pkg::LEVEL_W-1:0] n,
		input logic [acc_pkg::LEVEL_W-1:0] b,
		input logic [acc_pkg::CHAN_N-1:0][acc_pkg::LEVEL_W-1:0] c);
		pos_o <= p;
		neg_o <= n;
		bg_o <= b;
		chan_o <= c;
	endtask
	task automatic set_dig(input logic p, input logic n);
		pos_dig_o <= p;
		neg_dig_o <= n;
	endtask
endmodule

// File: sim/tb_acc_top.sv
// Self-checking bench for the comparator control block.
// Assumes the far-side model supplies levels and pins; the bench owns the register port.
module tb_acc_top;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int unsigned LW = acc_pkg::LEVEL_W;
	logic                                 CLK_I = 1'b0;
	logic                                 RST_I = 1'b1;
	logic                                 CE_I = 1'b1;
	logic [7:0]                           REG_ADDR_I = 8'h00;
	logic [7:0]                           REG_WDATA_I = 8'h00;
	logic                                 REG_WE_I = 1'b0;
	logic                                 REG_RE_I = 1'b0;
	logic                                 NEG_MUX_ENABLE_I = 1'b0;
	logic                                 CONVERTER_ENABLE_I = 1'b0;
	logic [acc_pkg::CHSEL_W-1:0]          CHANNEL_SELECT_I = '0;
	logic                                 GLOBAL_IRQ_ENABLE_I = 1'b0;
	logic                                 IRQ_VECTOR_TAKEN_I = 1'b0;
	logic [7:0]                           REG_RDATA_O;
	logic [LW-1:0]                        POS_PIN_LEVEL_I, NEG_PIN_LEVEL_I, BANDGAP_LEVEL_I;
	logic [acc_pkg::CHAN_N-1:0][LW-1:0]   CHANNEL_LEVEL_I;
	logic                                 IRQ_O, COMPARATOR_POWER_O, CAPTURE_INPUT_O;
	logic                                 CAPTURE_ROUTE_O, POS_PIN_DIGITAL_I, NEG_PIN_DIGITAL_I;
	logic                                 POS_PIN_READ_O, NEG_PIN_READ_O;
	logic                                 POS_BUFFER_EN_O, NEG_BUFFER_EN_O;
	int                                   fails = 0;
	int                                   cmp_count = 0;
	integer                               seed = 32'hcbd0;
	logic [7:0]                           d;
	logic [LW-1:0]                        ps, ns, bs;
	logic [acc_pkg::CHAN_N-1:0][LW-1:0]   ch;
	logic                                 bsel;
	int unsigned                          e0;

	always #50 CLK_I = ~CLK_I;

	acc_top i_dut (.CLK_I, .RST_I, .CE_I, .REG_ADDR_I, .REG_WDATA_I, .REG_WE_I, .REG_RE_I,
		.REG_RDATA_O, .POS_PIN_LEVEL_I, .NEG_PIN_LEVEL_I, .BANDGAP_LEVEL_I, .CHANNEL_LEVEL_I,
		.NEG_MUX_ENABLE_I, .CONVERTER_ENABLE_I, .CHANNEL_SELECT_I, .GLOBAL_IRQ_ENABLE_I,
		.IRQ_VECTOR_TAKEN_I, .IRQ_O, .COMPARATOR_POWER_O, .CAPTURE_INPUT_O, .CAPTURE_ROUTE_O,
		.POS_PIN_DIGITAL_I, .NEG_PIN_DIGITAL_I, .POS_PIN_READ_O, .NEG_PIN_READ_O,
		.POS_BUFFER_EN_O, .NEG_BUFFER_EN_O);
	acc_far i_far (.clk_i(CLK_I), .capture_i(CAPTURE_INPUT_O), .pos_o(POS_PIN_LEVEL_I),
		.neg_o(NEG_PIN_LEVEL_I), .bg_o(BANDGAP_LEVEL_I), .chan_o(CHANNEL_LEVEL_I),
		.pos_dig_o(POS_PIN_DIGITAL_I), .neg_dig_o(NEG_PIN_DIGITAL_I));

	// ------------------------------------------------------------------
	// Tasks and expectation functions
	// ------------------------------------------------------------------
	task automatic end_of_test();
		if (fails == 0 && cmp_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge CLK_I);
		REG_WE_I <= 1'b1;
		REG_ADDR_I <= a;
		REG_WDATA_I <= v;
		@(posedge CLK_I);
		REG_WE_I <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
		@(posedge CLK_I);
		REG_RE_I <= 1'b1;
		REG_ADDR_I <= a;
		@(posedge CLK_I);
		REG_RE_I <= 1'b0;
		@(negedge CLK_I);
		chk(REG_RDATA_O, exp, what);
	endtask
	task automatic lv(input logic [LW-1:0] p);
		@(posedge CLK_I);
		i_far.set_lv(p, 10'h100, 10'h000, '0);
		repeat (5) @(posedge CLK_I);
	endtask
	function automatic logic [LW-1:0] r10();
		logic [31:0] t;
		t = $random(seed);
		return t[LW-1:0];
	endfunction
	function automatic logic f_res(input logic bg, input logic me, input logic ae,
		input logic [2:0] s);
		logic [LW-1:0] pp, nn;
		pp = bg ? bs : ps;
		nn = (me && !ae) ? ch[s] : ns;
		return pp > nn;
	endfunction

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial begin
		repeat (12) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(8'h50, 8'h00, "ctrl reset");
		rd(8'h7F, 8'h00, "dis reset");
		chk({7'h00, COMPARATOR_POWER_O}, 8'h01, "power reset");
		rd(8'h10, 8'h00, "unmapped");
		for (int i = 0; i < 48; i++) begin
			ps = r10();
			ns = (i % 8 == 0) ? ps : r10();
			bs = r10();
			for (int k = 0; k < 8; k++) ch[k] = r10();
			bsel = ps[3];
			@(posedge CLK_I);
			i_far.set_lv(ps, ns, bs, ch);
			NEG_MUX_ENABLE_I <= bs[0];
			CONVERTER_ENABLE_I <= bs[1] & bs[2];
			CHANNEL_SELECT_I <= ns[6:4];
			wr(8'h50, {1'b0, bsel, 6'b01_0001});
			repeat (5) @(posedge CLK_I);
			d = {1'b0, bsel, f_res(bsel, bs[0], bs[1] & bs[2], ns[6:4]), 5'b0_0001};
			rd(8'h50, d, "compare");
		end
		@(posedge CLK_I);
		NEG_MUX_ENABLE_I <= 1'b0;
		for (int m = 0; m < 4; m++) begin
			lv(10'h000);
			wr(8'h50, 8'h10 | m[7:0]);
			lv(10'h3FF);
			d = 8'h20 | m[7:0] | ((m == 0 || m == 3) ? 8'h10 : 8'h00);
			rd(8'h50, d, "rise event");
			wr(8'h50, m[7:0]);
			rd(8'h50, d, "flag kept");
			wr(8'h50, 8'h10 | m[7:0]);
			lv(10'h000);
			d = m[7:0] | ((m == 0 || m == 2) ? 8'h10 : 8'h00);
			rd(8'h50, d, "fall event");
		end
		wr(8'h50, 8'h13);
		wr(8'h50, 8'h0B);
		GLOBAL_IRQ_ENABLE_I <= 1'b1;
		lv(10'h3FF);
		chk({7'h00, IRQ_O}, 8'h01, "irq on");
		rd(8'h60, 8'h01, "irq status");
		rd(8'h62, 8'h01, "irq enable");
		@(posedge CLK_I);
		GLOBAL_IRQ_ENABLE_I <= 1'b0;
		@(negedge CLK_I);
		chk({7'h00, IRQ_O}, 8'h00, "irq gie off");
		@(posedge CLK_I);
		GLOBAL_IRQ_ENABLE_I <= 1'b1;
		IRQ_VECTOR_TAKEN_I <= 1'b1;
		@(posedge CLK_I);
		IRQ_VECTOR_TAKEN_I <= 1'b0;
		@(negedge CLK_I);
		chk({7'h00, IRQ_O}, 8'h00, "irq vector");
		rd(8'h50, 8'h2B, "vector clear");
		lv(10'h000);
		lv(10'h3FF);
		wr(8'h61, 8'h01);
		rd(8'h60, 8'h00, "clear reg");
		rd(8'h61, 8'h00, "clear reads 0");
		wr(8'h50, 8'h13);
		lv(10'h000);
		wr(8'h50, 8'h07);
		e0 = i_far.cap_edges;
		lv(10'h3FF);
		chk({6'h00, CAPTURE_ROUTE_O, CAPTURE_INPUT_O}, 8'h03, "capture on");
		chk(8'(i_far.cap_edges - e0), 8'h01, "capture edge");
		wr(8'h50, 8'h13);
		repeat (3) @(posedge CLK_I);
		chk({6'h00, CAPTURE_ROUTE_O, CAPTURE_INPUT_O}, 8'h00, "capture off");
		wr(8'h50, 8'h83);
		@(negedge CLK_I);
		chk({7'h00, COMPARATOR_POWER_O}, 8'h00, "power off");
		repeat (5) @(posedge CLK_I);
		rd(8'h50, 8'h83, "off result");
		wr(8'h50, 8'h03);
		@(negedge CLK_I);
		chk({7'h00, COMPARATOR_POWER_O}, 8'h01, "power on");
		repeat (5) @(posedge CLK_I);
		rd(8'h50, 8'h33, "on result");
		@(posedge CLK_I);
		i_far.set_dig(1'b1, 1'b1);
		repeat (5) @(posedge CLK_I);
		chk({4'h0, POS_PIN_READ_O, NEG_PIN_READ_O, POS_BUFFER_EN_O, NEG_BUFFER_EN_O},
			8'h0F, "pins on");
		wr(8'h7F, 8'hFF);
		repeat (3) @(posedge CLK_I);
		chk({4'h0, POS_PIN_READ_O, NEG_PIN_READ_O, POS_BUFFER_EN_O, NEG_BUFFER_EN_O},
			8'h00, "pins off");
		rd(8'h7F, 8'h03, "dis upper");
		wr(8'h7F, 8'h01);
		repeat (3) @(posedge CLK_I);
		chk({4'h0, POS_PIN_READ_O, NEG_PIN_READ_O, POS_BUFFER_EN_O, NEG_BUFFER_EN_O},
			8'h05, "pos off only");
		@(posedge CLK_I);
		RST_I <= 1'b1;
		repeat (2) @(posedge CLK_I);
		RST_I <= 1'b0;
		rd(8'h7F, 8'h00, "mid reset");
		@(posedge CLK_I);
		CE_I <= 1'b0;
		wr(8'h7F, 8'h02);
		@(posedge CLK_I);
		CE_I <= 1'b1;
		rd(8'h7F, 8'h00, "ce freeze");
		end_of_test();
	end

	initial begin
		#(5000 * 100);
		fails++;
		end_of_test();
	end
endmodule
